// File: verification/testbench.sv
// Self-checking testbench for the turnaround, half-symbol timer, section reset and security register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mtrs_pkg::*;
   localparam int HC = 4;
   localparam int RC = 4;
   logic          clk_sys;
   logic          rst;
   logic          ce;
   logic [7:0]    avs_address;
   logic          avs_read;
   logic          avs_write;
   logic [31:0]   avs_writedata;
   logic [3:0]    avs_byteenable;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic [3:0]    turnaround_symbols;
   logic [3:0]    vco_settle_symbols;
   logic [15:0]   half_symbol_count;
   logic          half_symbol_running;
   logic          half_symbol_expired;
   logic          power_mgmt_reset;
   logic          baseband_reset;
   logic          mac_section_reset;
   logic          rx_decrypt_ignore;
   logic          rx_decrypt_start;
   mtrs_suite_t   rx_suite_select;
   mtrs_suite_t   tx_normal_suite_select;
   int            n_fail;
   int            n_checks;
   logic [31:0]   rd;
   int            cnt [5];

   mtrs_regs #(.RST_CYCLES(RC), .HALF_CYCLES(HC)) i_mtrs_regs (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .turnaround_symbols(turnaround_symbols), .vco_settle_symbols(vco_settle_symbols),
      .half_symbol_count(half_symbol_count), .half_symbol_running(half_symbol_running),
      .half_symbol_expired(half_symbol_expired), .power_mgmt_reset(power_mgmt_reset),
      .baseband_reset(baseband_reset), .mac_section_reset(mac_section_reset),
      .rx_decrypt_ignore(rx_decrypt_ignore), .rx_decrypt_start(rx_decrypt_start),
      .rx_suite_select(rx_suite_select), .tx_normal_suite_select(tx_normal_suite_select));

   always #10 clk_sys = ~clk_sys;

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_cnt(input int got, input int exp, input string what);
      n_checks++;
      if (got != exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s counted %0d expected %0d", $time, what, got, exp);
      end
   endtask

   // One Avalon transfer: hold the request until waitrequest is sampled low, return mid-cycle
   task automatic bus_xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address    <= {idx, 2'b00};
      avs_writedata  <= {24'h000000, d};
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= ~wr;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(negedge clk_sys);
      if (n >= 50)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: bus answer missing", $time);
         complete_run();
      end
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input string what);
      bus_xfer(1'b0, idx, 8'h00, 4'hF);
      check_val(rd, {24'h000000, exp}, what);
   endtask

   // Counts high cycles of power, baseband, mac reset, start and ignore over a number of edges
   task automatic watch(input int edges);
      cnt = '{0, 0, 0, 0, 0};
      repeat (edges)
      begin
         @(posedge clk_sys);
         cnt[0] += int'(power_mgmt_reset === 1'b1);
         cnt[1] += int'(baseband_reset === 1'b1);
         cnt[2] += int'(mac_section_reset === 1'b1);
         cnt[3] += int'(rx_decrypt_start === 1'b1);
         cnt[4] += int'(rx_decrypt_ignore === 1'b1);
      end
   endtask

   task automatic test_reset_values();
      check_val(32'(turnaround_symbols), 32'(TURN_RESET), "turn port");
      check_val(32'(vco_settle_symbols), 32'(VCO_RESET), "vco port");
      check_val(32'(half_symbol_count), 32'h0, "count port");
      check_val(32'({rx_suite_select, tx_normal_suite_select}), 32'h0, "suites");
      rd_chk(IDX_TURN, {TURN_RESET, TURN_LOW_FIX}, "turn reg");
      rd_chk(IDX_HST_LOW, 8'h00, "timer low");
      rd_chk(IDX_HST_HIGH, 8'h00, "timer high");
      rd_chk(IDX_STABILIZE, {VCO_RESET, SIFS_RESET}, "stab reg");
      rd_chk(IDX_SOFT_RST, 8'h00, "soft reset reg");
      rd_chk(IDX_RX_SEC, 8'h00, "sec reg");
      rd_chk(6'h00, 8'h00, "unmapped");
      $display("Test reset values done");
   endtask

   task automatic test_turnaround();
      logic [7:0] wv [6] = '{8'h38, 8'h98, 8'h28, 8'h18, 8'h08, 8'hF8};
      logic [3:0] ev [6] = '{4'h3, 4'h9, 4'h2, 4'h2, 4'h2, 4'hF};
      for (int i = 0; i < 6; i++)
      begin
         bus_xfer(1'b1, IDX_TURN, wv[i], 4'hF);
         check_val(32'(turnaround_symbols), 32'(ev[i]), "turn port");
         rd_chk(IDX_TURN, {ev[i], TURN_LOW_FIX}, "turn reg");
      end
      bus_xfer(1'b1, IDX_TURN, 8'h38, 4'hF);
      bus_xfer(1'b1, IDX_STABILIZE, 8'h95, 4'hF);
      check_val(32'(vco_settle_symbols), 32'h9, "vco port");
      check_cnt(int'(turnaround_symbols) + int'(vco_settle_symbols), 12, "turn sum");
      $display("Test turnaround done");
   endtask

   task automatic test_timer();
      int n;
      bus_xfer(1'b1, IDX_HST_LOW, 8'hAB, 4'hF);
      bus_xfer(1'b1, IDX_HST_HIGH, 8'hCD, 4'hF);
      check_val(32'(half_symbol_count), 32'h0000CDAB, "count port");
      check_val(32'(half_symbol_running), 32'h1, "running");
      rd_chk(IDX_HST_LOW, 8'hAB, "timer low");
      rd_chk(IDX_HST_HIGH, 8'hCD, "timer high");
      bus_xfer(1'b1, IDX_HST_LOW, 8'h55, 4'hE);
      rd_chk(IDX_HST_LOW, 8'hAB, "masked write");
      bus_xfer(1'b1, IDX_HST_LOW, 8'h02, 4'hF);
      bus_xfer(1'b1, IDX_HST_HIGH, 8'h00, 4'hF);
      n = 0;
      while (half_symbol_expired !== 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      check_cnt(int'(n >= 2 * HC - 2 && n <= 2 * HC + 2), 1, "expiry time");
      if (n >= 100)
         complete_run();
      watch(2);
      check_val(32'(half_symbol_running), 32'h0, "stopped");
      $display("Test timer done");
   endtask

   task automatic test_soft_reset();
      for (int b = 0; b < 3; b++)
      begin
         bus_xfer(1'b1, IDX_SOFT_RST, 8'(1 << b), 4'hF);
         watch(RC + 6);
         check_cnt(cnt[0], (b == RST_PWR_BIT) ? RC : 0, "power reset");
         check_cnt(cnt[1], (b == RST_BB_BIT) ? RC : 0, "baseband reset");
         check_cnt(cnt[2], (b == RST_MAC_BIT) ? RC : 0, "mac reset");
      end
      rd_chk(IDX_SOFT_RST, 8'h00, "soft reset reads");
      $display("Test soft reset done");
   endtask

   task automatic test_security();
      for (int c = 0; c < 8; c++)
      begin
         bus_xfer(1'b1, IDX_RX_SEC, {2'b00, 3'(c), 3'(7 - c)}, 4'hF);
         check_val(32'(rx_suite_select), 32'(c), "rx suite");
         check_val(32'(tx_normal_suite_select), 32'(7 - c), "tx suite");
         rd_chk(IDX_RX_SEC, {2'b00, 3'(c), 3'(7 - c)}, "sec reg");
      end
      bus_xfer(1'b1, IDX_RX_SEC, 8'h40 | 8'h12, 4'hF);
      watch(6);
      check_cnt(cnt[3], 1, "start strobe");
      check_cnt(cnt[4], 0, "ignore quiet");
      bus_xfer(1'b1, IDX_RX_SEC, 8'h80, 4'hF);
      watch(6);
      check_cnt(cnt[4], 1, "ignore strobe");
      check_cnt(cnt[3], 0, "start quiet");
      rd_chk(IDX_RX_SEC, 8'h00, "strobes read zero");
      $display("Test security done");
   endtask

   task automatic test_freeze_reset();
      bus_xfer(1'b1, IDX_SOFT_RST, 8'h01, 4'hF);
      @(posedge clk_sys);
      ce <= 1'b0;
      watch(5);
      ce <= 1'b1;
      check_cnt(cnt[2], 5, "frozen mac reset");
      watch(RC + 4);
      check_cnt(cnt[2], RC - 1, "mac reset after freeze");
      bus_xfer(1'b1, IDX_TURN, 8'h38, 4'hF);
      bus_xfer(1'b1, IDX_RX_SEC, 8'h1B, 4'hF);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check_val(32'(turnaround_symbols), 32'(TURN_RESET), "turn after reset");
      check_val(32'({rx_suite_select, tx_normal_suite_select}), 32'h0, "suites after reset");
      rd_chk(IDX_TURN, {TURN_RESET, TURN_LOW_FIX}, "turn reg after reset");
      $display("Test freeze and reset done");
   endtask

   initial
   begin
      clk_sys        = 1'b0;
      rst            = 1'b1;
      ce             = 1'b1;
      avs_address    = 8'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h00000000;
      avs_byteenable = 4'hF;
      n_fail         = 0;
      n_checks       = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      test_reset_values();
      test_turnaround();
      test_timer();
      test_soft_reset();
      test_security();
      test_freeze_reset();
      complete_run();
   end
endmodule
`default_nettype wire

// File: verilog/mtrs_half_symbol_timer.sv
// Half-symbol down-counter that flags expiry after the loaded number of 8 us periods
`timescale 1ns/1ps
`default_nettype none
module mtrs_half_symbol_timer
#(
   parameter int HALF_CYCLES = mtrs_pkg::HALF_SYMBOL_CYCLES,
   parameter int W           = 16
)
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         load,
   input  wire logic [W-1:0] count_init,
   output var  logic         running,
   output var  logic         expired
);
   import mtrs_pkg::*;

   logic [15:0]  prescale;
   logic [W-1:0] remain;
   logic [15:0]  next_prescale;
   logic [W-1:0] next_remain;
   logic         next_running;
   logic         next_expired;
   logic         tick;

   // One tick per half symbol period
   always_comb
   begin
      tick          = running && (prescale == 16'(HALF_CYCLES - 1));
      next_prescale = tick ? 16'h0000 : prescale + 16'h0001;
      next_remain   = remain;
      next_running  = running;
      next_expired  = 1'b0;
      if (!running)
         next_prescale = 16'h0000;
      if (load)
      begin
         next_prescale = 16'h0000;
         next_remain   = count_init;
         next_running  = (count_init != '0);
      end
      else if (tick)
      begin
         next_remain = remain - W'(1);
         if (remain == W'(1))
         begin
            next_running = 1'b0;
            next_expired = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         prescale <= 16'h0000;
         remain   <= '0;
         running  <= 1'b0;
         expired  <= 1'b0;
      end
      else if (ce)
      begin
         prescale <= next_prescale;
         remain   <= next_remain;
         running  <= next_running;
         expired  <= next_expired;
      end
   end

   a_tick_period: assert property (@(posedge clk_sys) disable iff (rst)
      running |-> prescale < 16'(HALF_CYCLES))
      else $error("half symbol prescaler overran");

endmodule
`default_nettype wire

// File: verilog/mtrs_pkg.sv
// Shared constants and types for the turnaround, half-symbol timer, reset and security register bank
package mtrs_pkg;

   // Bus geometry
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          IDX_W         = 6;

   // Register indices; byte address is four times the index
   localparam logic [5:0]  IDX_TURN      = 6'h27;
   localparam logic [5:0]  IDX_HST_LOW   = 6'h28;
   localparam logic [5:0]  IDX_HST_HIGH  = 6'h29;
   localparam logic [5:0]  IDX_SOFT_RST  = 6'h2A;
   localparam logic [5:0]  IDX_RX_SEC    = 6'h2B;
   localparam logic [5:0]  IDX_STABILIZE = 6'h2E;

   // Turnaround register fields
   localparam int          TURN_LSB      = 4;
   localparam logic [3:0]  TURN_RESET    = 4'h4;
   localparam logic [3:0]  TURN_MIN      = 4'h2;
   localparam logic [3:0]  TURN_LOW_FIX  = 4'h8;

   // Stabilization register fields
   localparam int          VCO_LSB       = 4;
   localparam logic [3:0]  VCO_RESET     = 4'h7;
   localparam logic [3:0]  SIFS_RESET    = 4'h5;

   // Half-symbol timer
   localparam logic [15:0] HST_RESET     = 16'h0000;

   // Soft reset bits
   localparam int          RST_MAC_BIT   = 0;
   localparam int          RST_BB_BIT    = 1;
   localparam int          RST_PWR_BIT   = 2;

   // Security control fields
   localparam int          TXN_SUITE_LSB = 0;
   localparam int          RX_SUITE_LSB  = 3;
   localparam int          START_BIT     = 6;
   localparam int          IGNORE_BIT    = 7;

   // Timing
   localparam int          CLK_MHZ            = 50;
   localparam int          SYMBOL_US          = 16;
   localparam int          HALF_SYMBOL_US     = 8;
   localparam int          HALF_SYMBOL_CYCLES = HALF_SYMBOL_US * CLK_MHZ;
   localparam int          SECTION_RST_CYCLES = 4;

   // Security suite codes
   typedef enum logic [2:0] {
      MTRS_SUITE_NONE       = 3'h0,
      MTRS_SUITE_CTR        = 3'h1,
      MTRS_SUITE_CCM_128    = 3'h2,
      MTRS_SUITE_CCM_64     = 3'h3,
      MTRS_SUITE_CCM_32     = 3'h4,
      MTRS_SUITE_CBCMAC_128 = 3'h5,
      MTRS_SUITE_CBCMAC_64  = 3'h6,
      MTRS_SUITE_CBCMAC_32  = 3'h7
   } mtrs_suite_t;

   // Bus handshake states
   typedef enum logic [1:0] {
      MTRS_BUS_IDLE = 2'b01,
      MTRS_BUS_ACK  = 2'b10
   } mtrs_bus_t;

endpackage

// File: verilog/mtrs_pulse_gen.sv
// Self-clearing pulse of programmable length, restarted by a start strobe
`timescale 1ns/1ps
`default_nettype none
module mtrs_pulse_gen
#(
   parameter int LEN = 4
)
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic start,
   output var  logic pulse
);
   import mtrs_pkg::*;

   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic       next_pulse;

   // Count down and drop the pulse by itself
   always_comb
   begin
      next_cnt   = cnt;
      if (start)
         next_cnt = LEN[7:0];
      else if (cnt != 8'h00)
         next_cnt = cnt - 8'h01;
      next_pulse = (next_cnt != 8'h00);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cnt   <= 8'h00;
         pulse <= 1'b0;
      end
      else if (ce)
      begin
         cnt   <= next_cnt;
         pulse <= next_pulse;
      end
   end

   a_pulse_start: assert property (@(posedge clk_sys) disable iff (rst)
      ce && start |=> pulse)
      else $error("pulse did not start");

   a_pulse_end: assert property (@(posedge clk_sys) disable iff (rst)
      ce && !start && cnt == 8'h01 |=> !pulse && cnt == 8'h00)
      else $error("pulse did not clear itself");

endmodule
`default_nettype wire

// File: verilog/mtrs_regs.sv
// Turnaround, half-symbol timer, section reset and receive security register bank on Avalon-MM
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mtrs_regs
#(
   parameter int RST_CYCLES  = mtrs_pkg::SECTION_RST_CYCLES,
   parameter int HALF_CYCLES = mtrs_pkg::HALF_SYMBOL_CYCLES
)
(
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   input  wire logic                          ce,
   input  wire logic [mtrs_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [mtrs_pkg::DATA_W-1:0]   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output var  logic [mtrs_pkg::DATA_W-1:0]   avs_readdata,
   output var  logic                          avs_waitrequest,
   output var  logic [3:0]                    turnaround_symbols,
   output var  logic [3:0]                    vco_settle_symbols,
   output var  logic [15:0]                   half_symbol_count,
   output var  logic                          half_symbol_running,
   output var  logic                          half_symbol_expired,
   output var  logic                          power_mgmt_reset,
   output var  logic                          baseband_reset,
   output var  logic                          mac_section_reset,
   output var  logic                          rx_decrypt_ignore,
   output var  logic                          rx_decrypt_start,
   output var  mtrs_pkg::mtrs_suite_t         rx_suite_select,
   output var  mtrs_pkg::mtrs_suite_t         tx_normal_suite_select
);
   import mtrs_pkg::*;

   // Decoding used for reads only; writes decode the index in their own case
   function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
      begin
         is_mapped = (idx == IDX_TURN) || (idx == IDX_HST_LOW) || (idx == IDX_HST_HIGH) ||
                     (idx == IDX_SOFT_RST) || (idx == IDX_RX_SEC) || (idx == IDX_STABILIZE);
      end
   endfunction

   function automatic logic [3:0] turn_floor(input logic [3:0] v);
      begin
         turn_floor = (v < TURN_MIN) ? TURN_MIN : v;
      end
   endfunction

   logic [IDX_W-1:0] idx;
   logic [7:0]       wbyte;
   logic             wr_fire;
   logic             rd_take;
   logic [7:0]       rd_byte;

   mtrs_bus_t        bus_state;
   mtrs_bus_t        next_bus_state;
   logic             next_waitrequest;
   logic [DATA_W-1:0] next_readdata;

   logic [3:0]       sifs_symbols;
   logic [3:0]       next_turnaround;
   logic [3:0]       next_vco_settle;
   logic [3:0]       next_sifs;
   logic [15:0]      next_half_count;
   mtrs_suite_t      next_rx_suite;
   mtrs_suite_t      next_tx_suite;
   logic             hst_load;
   logic [4:0]       pulse_start;
   logic [4:0]       pulse_out;

   assign idx     = avs_address[ADDR_W-1:2];
   assign wbyte   = avs_writedata[7:0];
   assign wr_fire = (bus_state == MTRS_BUS_ACK) && avs_write && avs_byteenable[0];
   assign rd_take = (bus_state == MTRS_BUS_IDLE) && avs_read && !avs_write;

   // Read value of the addressed register
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (1'b1)
         idx == IDX_TURN:      rd_byte = {turnaround_symbols, TURN_LOW_FIX};
         idx == IDX_HST_LOW:   rd_byte = half_symbol_count[7:0];
         idx == IDX_HST_HIGH:  rd_byte = half_symbol_count[15:8];
         idx == IDX_SOFT_RST:  rd_byte = 8'h00;
         idx == IDX_RX_SEC:    rd_byte = {2'b00, rx_suite_select, tx_normal_suite_select};
         idx == IDX_STABILIZE: rd_byte = {vco_settle_symbols, sifs_symbols};
         default:              rd_byte = 8'h00;
      endcase
      if (!is_mapped(idx))
         rd_byte = 8'h00;
   end

   // Bus handshake: one wait cycle, then answer
   always_comb
   begin
      next_bus_state   = bus_state;
      next_waitrequest = 1'b1;
      next_readdata    = avs_readdata;
      unique case (bus_state)
         MTRS_BUS_IDLE:
         begin
            if (avs_read || avs_write)
            begin
               next_bus_state   = MTRS_BUS_ACK;
               next_waitrequest = 1'b0;
               next_readdata    = rd_take ? {24'h000000, rd_byte} : '0;
            end
         end
         MTRS_BUS_ACK:
         begin
            next_bus_state   = MTRS_BUS_IDLE;
            next_waitrequest = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bus_state       <= MTRS_BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= '0;
      end
      else if (ce)
      begin
         bus_state       <= next_bus_state;
         avs_waitrequest <= next_waitrequest;
         avs_readdata    <= next_readdata;
      end
   end

   // Register writes
   always_comb
   begin
      next_turnaround = turnaround_symbols;
      next_vco_settle = vco_settle_symbols;
      next_sifs       = sifs_symbols;
      next_half_count = half_symbol_count;
      next_rx_suite   = rx_suite_select;
      next_tx_suite   = tx_normal_suite_select;
      hst_load        = 1'b0;
      pulse_start     = 5'h00;
      if (wr_fire)
      begin
         unique case (1'b1)
            idx == IDX_TURN:
               next_turnaround = turn_floor(wbyte[TURN_LSB +: 4]);
            idx == IDX_HST_LOW:
               next_half_count[7:0] = wbyte;
            idx == IDX_HST_HIGH:
            begin
               next_half_count[15:8] = wbyte;
               hst_load              = 1'b1;
            end
            idx == IDX_SOFT_RST:
            begin
               pulse_start[0] = wbyte[RST_MAC_BIT];
               pulse_start[1] = wbyte[RST_BB_BIT];
               pulse_start[2] = wbyte[RST_PWR_BIT];
            end
            idx == IDX_RX_SEC:
            begin
               next_rx_suite  = mtrs_suite_t'(wbyte[RX_SUITE_LSB +: 3]);
               next_tx_suite  = mtrs_suite_t'(wbyte[TXN_SUITE_LSB +: 3]);
               pulse_start[3] = wbyte[START_BIT];
               pulse_start[4] = wbyte[IGNORE_BIT];
            end
            idx == IDX_STABILIZE:
            begin
               next_vco_settle = wbyte[VCO_LSB +: 4];
               next_sifs       = wbyte[3:0];
            end
            default:
            begin
               next_turnaround = turnaround_symbols;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         turnaround_symbols     <= TURN_RESET;
         vco_settle_symbols     <= VCO_RESET;
         sifs_symbols           <= SIFS_RESET;
         half_symbol_count      <= HST_RESET;
         rx_suite_select        <= MTRS_SUITE_NONE;
         tx_normal_suite_select <= MTRS_SUITE_NONE;
      end
      else if (ce)
      begin
         turnaround_symbols     <= next_turnaround;
         vco_settle_symbols     <= next_vco_settle;
         sifs_symbols           <= next_sifs;
         half_symbol_count      <= next_half_count;
         rx_suite_select        <= next_rx_suite;
         tx_normal_suite_select <= next_tx_suite;
      end
   end

   // Section resets stretch over several cycles, decryption strobes last one
   genvar g;
   generate
      for (g = 0; g < 5; g++)
      begin : g_pulse
         mtrs_pulse_gen
         #(
            .LEN (g < 3 ? RST_CYCLES : 1)
         )
         u_pulse
         (
            .clk_sys (clk_sys),
            .rst     (rst),
            .ce      (ce),
            .start   (pulse_start[g]),
            .pulse   (pulse_out[g])
         );
      end
   endgenerate

   assign mac_section_reset = pulse_out[0];
   assign baseband_reset    = pulse_out[1];
   assign power_mgmt_reset  = pulse_out[2];
   assign rx_decrypt_start  = pulse_out[3];
   assign rx_decrypt_ignore = pulse_out[4];

   mtrs_half_symbol_timer
   #(
      .HALF_CYCLES (HALF_CYCLES),
      .W           (16)
   )
   u_timer
   (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .ce         (ce),
      .load       (hst_load),
      .count_init (next_half_count),
      .running    (half_symbol_running),
      .expired    (half_symbol_expired)
   );

   sequence s_write_to(logic [IDX_W-1:0] r);
      ce && wr_fire && idx == r;
   endsequence

   sequence s_request_seen;
      ce && bus_state == MTRS_BUS_IDLE && (avs_read || avs_write);
   endsequence

   a_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
      s_request_seen |=> !avs_waitrequest ##1 (avs_waitrequest || !$past(ce)))
      else $error("waitrequest not low for exactly one cycle");

   a_turn_floor: assert property (@(posedge clk_sys) disable iff (rst)
      turnaround_symbols >= TURN_MIN)
      else $error("turnaround below minimum");

   a_turn_write: assert property (@(posedge clk_sys) disable iff (rst)
      s_write_to(IDX_TURN) |=> turnaround_symbols == turn_floor($past(wbyte[TURN_LSB +: 4])))
      else $error("turnaround write not applied");

   a_turn_read: assert property (@(posedge clk_sys) disable iff (rst)
      ce && rd_take && idx == IDX_TURN |=> avs_readdata[7:0] == {$past(turnaround_symbols), 4'h8})
      else $error("turnaround read wrong");

   a_hst_write: assert property (@(posedge clk_sys) disable iff (rst)
      s_write_to(IDX_HST_HIGH) |=> half_symbol_count[15:8] == $past(wbyte) ##1 half_symbol_running == 1'b1 ||
      half_symbol_count == 16'h0000)
      else $error("half symbol high byte not applied");

   a_soft_start: assert property (@(posedge clk_sys) disable iff (rst)
      s_write_to(IDX_SOFT_RST) ##0 wbyte[RST_MAC_BIT] |=> mac_section_reset [*2])
      else $error("mac reset pulse missing");

   a_soft_read: assert property (@(posedge clk_sys) disable iff (rst)
      ce && rd_take && idx == IDX_SOFT_RST |=> avs_readdata == '0)
      else $error("soft reset read not zero");

   a_suite_write: assert property (@(posedge clk_sys) disable iff (rst)
      s_write_to(IDX_RX_SEC) |=> rx_suite_select == $past(wbyte[5:3]) && tx_normal_suite_select == $past(wbyte[2:0]))
      else $error("suite select not applied");

   a_strobe_cause: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(rx_decrypt_start) |-> $past(wr_fire && idx == IDX_RX_SEC && wbyte[START_BIT]))
      else $error("decrypt start without write");

   a_vco_write: assert property (@(posedge clk_sys) disable iff (rst)
      s_write_to(IDX_STABILIZE) |=> vco_settle_symbols == $past(wbyte[7:4]))
      else $error("vco settle not applied");

endmodule
`default_nettype wire
